// File: rtl/ftos_top.sv
// Purpose: Thermal override, fan-start hysteresis and spin-up end
//          logic for three duty outputs driven from four zones.
// Assumes: Ramp duty, fan-start limits, lock and zone map come from
//          neighbouring logic; tick_i paces the spin-up timer.
// Notes:   Register port is the device's internal byte register port.
module ftos_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire ftos_pkg::ftos_byte_type reg_wdata_i,
    output ftos_pkg::ftos_byte_type reg_rdata_o,
    input wire logic cfg_lock_i,
    input wire logic auto_mode_i,
    input wire logic tick_i,
    input wire ftos_pkg::ftos_rawtemp_type [3:0] zone_temp_i,
    input wire ftos_pkg::ftos_byte_type [3:0] start_lim_i,
    input wire ftos_pkg::ftos_fan_cfg_type [2:0] fan_cfg_i,
    input wire ftos_pkg::ftos_tach_type [2:0] tach_i,
    output ftos_pkg::ftos_byte_type [2:0] duty_o,
    output logic [2:0] spinning_o,
    output logic [3:0] override_o,
    output logic [3:0] speed_off_o
);
    import ftos_pkg::*;

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        ftos_byte_type [3:0] abs_lim;
        ftos_byte_type hyst12;
        ftos_byte_type hyst34;
        ftos_byte_type spin_cfg;
        logic [3:0] ovr;
        logic [3:0] hold;
        ftos_spin_type [2:0] spin;
        logic [2:0][15:0] spin_cnt;
        ftos_byte_type [2:0] duty;
        ftos_byte_type rdata;
    } ftos_state_type;

    ftos_state_type st_reg;
    ftos_state_type st_next;

    logic [3:0][3:0] zone_hyst;
    ftos_zone_flags_type [3:0] zflags;

    // --------------------------------------------------------------
    // Zone comparators
    // --------------------------------------------------------------
    always_comb
    begin
        zone_hyst[0] = st_reg.hyst12[HYST_HI_LSB +: 4];
        zone_hyst[1] = st_reg.hyst12[HYST_LO_LSB +: 4];
        zone_hyst[2] = st_reg.hyst34[HYST_HI_LSB +: 4];
        zone_hyst[3] = st_reg.hyst34[HYST_LO_LSB +: 4];
    end

    genvar gz;
    generate
        for (gz = 0; gz < NUM_ZONES; gz++)
        begin : g_zone
            ftos_zone_cmp u_cmp (
                .temp_i(zone_temp_i[gz]),
                .abs_lim_i(st_reg.abs_lim[gz]),
                .start_lim_i(start_lim_i[gz]),
                .hyst_i(zone_hyst[gz]),
                .flags_o(zflags[gz])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    logic any_ovr;
    logic [2:0] fan_on;
    logic [2:0] fan_ramp;
    logic [2:0] fan_ovr;
    logic [2:0] fast;
    ftos_byte_type rd;
    ftos_byte_type lo;
    ftos_byte_type hi;
    ftos_byte_type dsel;

    always_comb
    begin
        st_next = st_reg;
        rd = DUTY_OFF;
        lo = DUTY_OFF;
        hi = DUTY_OFF;
        dsel = DUTY_OFF;
        fan_on = 3'b000;
        fan_ramp = 3'b000;
        fan_ovr = 3'b000;
        fast = 3'b000;

        // Configuration writes, frozen by the lock
        if (reg_wr_i && !cfg_lock_i)
        begin
            case (reg_addr_i)
                ZONE1_ABS_OFS: st_next.abs_lim[0] = reg_wdata_i;
                ZONE2_ABS_OFS: st_next.abs_lim[1] = reg_wdata_i;
                ZONE3_ABS_OFS: st_next.abs_lim[2] = reg_wdata_i;
                ZONE4_ABS_OFS: st_next.abs_lim[3] = reg_wdata_i;
                ZONE12_HYST_OFS: st_next.hyst12 = reg_wdata_i;
                ZONE34_HYST_OFS: st_next.hyst34 = reg_wdata_i;
                SPINUP_CFG_OFS:
                    st_next.spin_cfg = reg_wdata_i & SPINUP_CFG_WMASK;
                default: st_next.spin_cfg = st_reg.spin_cfg;
            endcase
        end

        // Reads return stored values, locked or not
        case (reg_addr_i)
            ZONE1_ABS_OFS: rd = st_reg.abs_lim[0];
            ZONE2_ABS_OFS: rd = st_reg.abs_lim[1];
            ZONE3_ABS_OFS: rd = st_reg.abs_lim[2];
            ZONE4_ABS_OFS: rd = st_reg.abs_lim[3];
            ZONE12_HYST_OFS: rd = st_reg.hyst12;
            ZONE34_HYST_OFS: rd = st_reg.hyst34;
            SPINUP_CFG_OFS: rd = st_reg.spin_cfg;
            default: rd = DUTY_OFF;
        endcase
        st_next.rdata = rd;

        // Per-zone override and run latches
        for (int i = 0; i < NUM_ZONES; i++)
        begin
            if (zflags[i].over_abs)
                st_next.ovr[i] = 1'b1;
            else if (zflags[i].clear_abs)
                st_next.ovr[i] = 1'b0;
            if (zflags[i].at_start)
                st_next.hold[i] = 1'b1;
            else if (zflags[i].clear_start)
                st_next.hold[i] = 1'b0;
        end
        any_ovr = auto_mode_i && (|st_reg.ovr);

        // Per-fan duty and spin-up
        for (int j = 0; j < NUM_FANS; j++)
        begin
            for (int i = 0; i < NUM_ZONES; i++)
            begin
                if (fan_cfg_i[j].zone_map[i])
                begin
                    fan_on[j] = fan_on[j] | st_reg.hold[i];
                    fan_ramp[j] = fan_ramp[j] | zflags[i].above_start;
                    fan_ovr[j] = fan_ovr[j] | st_reg.ovr[i];
                end
            end

            // Speed check is meaningful only with the input enabled
            fast[j] = st_reg.spin_cfg[EARLY_EXIT_LSB + j]
                && !st_reg.spin_cfg[SPEED_OFF_LSB + j]
                && (tach_i[j].count < tach_i[j].min_count);

            case (st_reg.spin)
                default: st_next.spin[j] = st_reg.spin[j];
            endcase

            case (st_reg.spin[j])
                SPIN_OFF:
                begin
                    if (auto_mode_i && fan_on[j])
                    begin
                        st_next.spin[j] = SPIN_RUN;
                        st_next.spin_cnt[j] = fan_cfg_i[j].spin_len;
                    end
                end
                SPIN_RUN:
                begin
                    if (!auto_mode_i || !fan_on[j])
                        st_next.spin[j] = SPIN_OFF;
                    else if (fast[j])
                        st_next.spin[j] = SPIN_DONE;
                    else if (st_reg.spin_cnt[j] == SPIN_CNT_ZERO)
                        st_next.spin[j] = SPIN_DONE;
                    else if (tick_i)
                        st_next.spin_cnt[j] =
                            st_reg.spin_cnt[j] - SPIN_CNT_ONE;
                end
                SPIN_DONE:
                begin
                    if (!auto_mode_i || !fan_on[j])
                        st_next.spin[j] = SPIN_OFF;
                end
                default: st_next.spin[j] = SPIN_OFF;
            endcase

            // Clamp ramp into the min..max window
            lo = fan_cfg_i[j].min_duty;
            hi = fan_cfg_i[j].max_duty;
            if (fan_cfg_i[j].ramp < lo)
                dsel = lo;
            else if (fan_cfg_i[j].ramp > hi)
                dsel = hi;
            else
                dsel = fan_cfg_i[j].ramp;

            if (!auto_mode_i)
                st_next.duty[j] = fan_cfg_i[j].ramp;
            else if (any_ovr)
                st_next.duty[j] = DUTY_FULL;
            else if (fan_ovr[j])
                st_next.duty[j] = DUTY_FULL;
            else if (st_reg.spin[j] == SPIN_RUN)
                st_next.duty[j] = DUTY_FULL;
            else if (fan_ramp[j])
                st_next.duty[j] = dsel;
            else if (fan_on[j])
                st_next.duty[j] = fan_cfg_i[j].min_duty;
            else
                st_next.duty[j] = DUTY_OFF;
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_reg.abs_lim[0] <= ZONE123_ABS_RST;
            st_reg.abs_lim[1] <= ZONE123_ABS_RST;
            st_reg.abs_lim[2] <= ZONE123_ABS_RST;
            st_reg.abs_lim[3] <= ZONE4_ABS_RST;
            st_reg.hyst12 <= HYST_RST;
            st_reg.hyst34 <= HYST_RST;
            st_reg.spin_cfg <= SPINUP_CFG_RST;
            st_reg.ovr <= 4'h0;
            st_reg.hold <= 4'h0;
            st_reg.spin <= {SPIN_OFF, SPIN_OFF, SPIN_OFF};
            st_reg.spin_cnt <= '0;
            st_reg.duty <= '0;
            st_reg.rdata <= DUTY_OFF;
        end
        else if (ce_i)
        begin
            st_reg <= st_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    always_comb
    begin
        reg_rdata_o = st_reg.rdata;
        duty_o = st_reg.duty;
        override_o = st_reg.ovr;
        speed_off_o = st_reg.spin_cfg[SPEED_OFF_LSB +: 4];
        for (int k = 0; k < NUM_FANS; k++)
        begin
            spinning_o[k] = (st_reg.spin[k] == SPIN_RUN);
        end
    end

endmodule

// File: rtl/ftos_pkg.sv
// Purpose: Shared constants, types and helpers for the fan thermal
//          override and spin-up block.
// Assumes: Temperatures arrive as 9-bit two's complement whole degrees.
// Notes:   Register offsets are the byte addresses of the register port.
package ftos_pkg;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [7:0] ZONE4_ABS_OFS = 8'h3d;
    localparam logic [7:0] ZONE1_ABS_OFS = 8'h6a;
    localparam logic [7:0] ZONE2_ABS_OFS = 8'h6b;
    localparam logic [7:0] ZONE3_ABS_OFS = 8'h6c;
    localparam logic [7:0] ZONE12_HYST_OFS = 8'h6d;
    localparam logic [7:0] ZONE34_HYST_OFS = 8'h6e;
    localparam logic [7:0] SPINUP_CFG_OFS = 8'h75;

    localparam logic [7:0] ZONE123_ABS_RST = 8'h64;
    localparam logic [7:0] ZONE4_ABS_RST = 8'h00;
    localparam logic [7:0] HYST_RST = 8'h44;
    localparam logic [7:0] SPINUP_CFG_RST = 8'h00;

    // --------------------------------------------------------------
    // Field layout and codes
    // --------------------------------------------------------------
    localparam int HYST_HI_LSB = 4;
    localparam int HYST_LO_LSB = 0;
    localparam int EARLY_EXIT_LSB = 0;
    localparam int SPEED_OFF_LSB = 4;
    // Bit 3 is reserved and reads zero
    localparam logic [7:0] SPINUP_CFG_WMASK = 8'hf7;
    localparam logic [7:0] ABS_DISABLE = 8'h80;
    localparam logic [7:0] TEMP_MAX = 8'h7f;
    localparam logic [7:0] TEMP_MIN = 8'h80;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [15:0] SPIN_CNT_ZERO = 16'h0000;
    localparam logic [15:0] SPIN_CNT_ONE = 16'h0001;

    localparam int NUM_ZONES = 4;
    localparam int NUM_FANS = 3;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef logic [8:0] ftos_rawtemp_type;
    typedef logic [7:0] ftos_byte_type;

    typedef enum logic [1:0] {
        SPIN_OFF = 2'b00,
        SPIN_RUN = 2'b01,
        SPIN_DONE = 2'b10
    } ftos_spin_type;

    typedef struct packed {
        logic over_abs;
        logic clear_abs;
        logic above_start;
        logic at_start;
        logic clear_start;
    } ftos_zone_flags_type;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] min_count;
    } ftos_tach_type;

    typedef struct packed {
        ftos_byte_type ramp;
        ftos_byte_type min_duty;
        ftos_byte_type max_duty;
        logic [3:0] zone_map;
        logic [15:0] spin_len;
    } ftos_fan_cfg_type;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic signed [7:0] sat_temp(input ftos_rawtemp_type t);
        logic signed [8:0] s;
        s = $signed(t);
        if (s > $signed({1'b0, TEMP_MAX}))
            sat_temp = TEMP_MAX;
        else if (s < $signed({1'b1, TEMP_MIN}))
            sat_temp = TEMP_MIN;
        else
            sat_temp = s[7:0];
    endfunction

    function automatic logic signed [7:0] sat_sub(input ftos_byte_type lim,
                                                  input logic [3:0] hyst);
        logic signed [8:0] d;
        d = $signed({lim[7], lim}) - $signed({5'b0_0000, hyst});
        if (d < $signed({1'b1, TEMP_MIN}))
            sat_sub = TEMP_MIN;
        else
            sat_sub = d[7:0];
    endfunction

endpackage

// File: rtl/ftos_zone_cmp.sv
// Purpose: Signed comparisons of one zone against its limits.
// Assumes: Absolute limit and hysteresis come from stored registers; start limit from an input.
// Notes:   Purely combinational; state lives in the top module.
module ftos_zone_cmp (
    input wire ftos_pkg::ftos_rawtemp_type temp_i,
    input wire ftos_pkg::ftos_byte_type abs_lim_i,
    input wire ftos_pkg::ftos_byte_type start_lim_i,
    input wire logic [3:0] hyst_i,
    output ftos_pkg::ftos_zone_flags_type flags_o
);
    import ftos_pkg::*;

    logic signed [7:0] t;
    logic signed [7:0] abs_thr;
    logic signed [7:0] start_thr;
    logic abs_on;

    always_comb
    begin
        t = sat_temp(temp_i);
        abs_thr = sat_sub(abs_lim_i, hyst_i);
        start_thr = sat_sub(start_lim_i, hyst_i);
        abs_on = (abs_lim_i != ABS_DISABLE);
        flags_o.over_abs = abs_on && (t > $signed(abs_lim_i));
        // Release point: dropped by at least the hysteresis
        flags_o.clear_abs = !abs_on || (t <= abs_thr);
        flags_o.above_start = t > $signed(start_lim_i);
        flags_o.at_start = t >= $signed(start_lim_i);
        // Stop point: strictly more than the hysteresis below
        flags_o.clear_start = t < start_thr;
    end

endmodule

// File: bench/ftos_asserts.sv
// Purpose: Port assertions for the thermal override block.
// Assumes: Shadows track zone 1 limit, hysteresis and spin config.
// Notes: Zone 1 and fan 1 stand in for their siblings.
module ftos_asserts (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire ftos_pkg::ftos_byte_type reg_wdata_i,
    input wire ftos_pkg::ftos_byte_type reg_rdata_o,
    input wire logic cfg_lock_i,
    input wire logic auto_mode_i,
    input wire ftos_pkg::ftos_rawtemp_type [3:0] zone_temp_i,
    input wire ftos_pkg::ftos_tach_type [2:0] tach_i,
    input wire ftos_pkg::ftos_byte_type [2:0] duty_o,
    input wire logic [2:0] spinning_o,
    input wire logic [3:0] override_o
);
    import ftos_pkg::*;
    ftos_byte_type lim1_reg;
    ftos_byte_type hyst_reg;
    ftos_byte_type cfg_reg;
    logic signed [9:0] z1, t1, l1, r1, rs;
    logic gt1, le1;
    // Temperature saturates high only; low side cannot change outcomes
    assign z1 = {zone_temp_i[0][8], zone_temp_i[0]};
    assign t1 = (z1 > 10'sd127) ? 10'sd127 : z1;
    assign l1 = {{2{lim1_reg[7]}}, lim1_reg};
    assign r1 = l1 - {6'h00, hyst_reg[7:4]};
    assign rs = (r1 < -10'sd128) ? -10'sd128 : r1;
    assign gt1 = t1 > l1;
    assign le1 = t1 <= rs;
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lim1_reg <= 8'h64;
            hyst_reg <= 8'h44;
            cfg_reg <= 8'h00;
        end
        else if (ce_i && reg_wr_i && !cfg_lock_i)
        begin
            if (reg_addr_i == ZONE1_ABS_OFS)
                lim1_reg <= reg_wdata_i;
            if (reg_addr_i == ZONE12_HYST_OFS)
                hyst_reg <= reg_wdata_i;
            if (reg_addr_i == SPINUP_CFG_OFS)
                cfg_reg <= reg_wdata_i;
        end
    end
    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    ovr_set_a: assert property (
        ce_i && auto_mode_i && gt1 && lim1_reg != ABS_DISABLE
        |=> override_o[0]) else $error("override did not set");
    ovr_off_a: assert property (
        ce_i && lim1_reg == ABS_DISABLE |=> !override_o[0])
        else $error("disabled zone overrides");
    ovr_hold_a: assert property (
        ce_i && auto_mode_i && override_o[0] && !le1
        && lim1_reg != ABS_DISABLE |=> override_o[0])
        else $error("override released early");
    ovr_rel_a: assert property (
        ce_i && le1 |=> !override_o[0])
        else $error("override not released");
    sat_limit_a: assert property (
        ce_i && lim1_reg == TEMP_MAX && !override_o[0] |=> !override_o[0])
        else $error("saturated temp overrides");
    full_duty_a: assert property (
        ce_i && auto_mode_i && (|override_o) |=> duty_o == {3{DUTY_FULL}})
        else $error("override duty not full");
    rd_limit_a: assert property (
        ce_i && reg_addr_i == ZONE1_ABS_OFS |=> reg_rdata_o == $past(lim1_reg))
        else $error("limit read mismatch");
    rd_hyst_a: assert property (
        ce_i && reg_addr_i == ZONE12_HYST_OFS
        |-> ##1 reg_rdata_o == $past(hyst_reg))
        else $error("hysteresis read mismatch");
    early_exit_a: assert property (
        ce_i && auto_mode_i && spinning_o[0] && cfg_reg[0] && !cfg_reg[4]
        && tach_i[0].count < tach_i[0].min_count |=> !spinning_o[0])
        else $error("spin-up did not end early");
    cover property (auto_mode_i && override_o[0]);
    cover property ($fell(spinning_o[0]));
    cover property (cfg_lock_i && reg_wr_i);
endmodule

bind ftos_top ftos_asserts u_chk (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cfg_lock_i(cfg_lock_i), .auto_mode_i(auto_mode_i),
    .zone_temp_i(zone_temp_i), .tach_i(tach_i), .duty_o(duty_o),
    .spinning_o(spinning_o), .override_o(override_o)
);

// File: bench/ftos_fan_model.sv
// Purpose: Behavioural fan turning duty into a tach period count.
// Assumes: Speed builds a step per clock while driven.
// Notes: A stalled fan never speeds up, to exercise timeouts.
module ftos_fan_model (
    input wire logic ref_clk_i,
    input wire ftos_pkg::ftos_byte_type duty_i,
    input wire logic stall_i,
    output logic [15:0] count_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ftos_pkg::*;
    initial count_o = 16'hffff;
    // Long period when slow, short when fast
    always @(posedge ref_clk_i)
    begin
        if (duty_i == DUTY_OFF || stall_i)
            count_o <= 16'hffff;
        else if (count_o > 16'h1fff)
            count_o <= count_o - 16'h1000;
    end
endmodule

// File: bench/ftos_tb.sv
// Purpose: Self-checking bench for the thermal override block.
// Assumes: Inputs change at falling edges; outputs read there too.
// Notes: A note queue pairs each expectation with its observation.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ftos_pkg::*;
    typedef struct {
        int kind;
        logic [23:0] val;
    } ftos_note_type;
    logic ref_clk_i, rst_b_i, ce_i, reg_wr_i, cfg_lock_i;
    logic auto_mode_i, tick_i;
    logic [7:0] reg_addr_i;
    ftos_byte_type reg_wdata_i, reg_rdata_o, rp;
    ftos_rawtemp_type [3:0] zone_temp_i;
    ftos_byte_type [3:0] start_lim_i;
    ftos_fan_cfg_type [2:0] fan_cfg_i;
    wire ftos_tach_type [2:0] tach_i;
    wire [15:0] cnt [3];
    ftos_byte_type [2:0] duty_o;
    logic [2:0] spinning_o, stall;
    logic [3:0] override_o, speed_off_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 32'hf5e1;
    ftos_note_type notes[$];
    ftos_note_type nt;
    event obs_ev;
    ftos_byte_type offs [8] = '{ZONE4_ABS_OFS, ZONE1_ABS_OFS,
        ZONE2_ABS_OFS, ZONE3_ABS_OFS, ZONE12_HYST_OFS, ZONE34_HYST_OFS,
        SPINUP_CFG_OFS, 8'h40};
    ftos_byte_type regv [8] = '{8'h00, 8'h64, 8'h64, 8'h64, 8'h44,
        8'h44, 8'h00, 8'h00};

    ftos_top dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .cfg_lock_i(cfg_lock_i), .auto_mode_i(auto_mode_i),
        .tick_i(tick_i), .zone_temp_i(zone_temp_i),
        .start_lim_i(start_lim_i), .fan_cfg_i(fan_cfg_i),
        .tach_i(tach_i), .duty_o(duty_o), .spinning_o(spinning_o),
        .override_o(override_o), .speed_off_o(speed_off_o));
    for (genvar f = 0; f < NUM_FANS; f++)
    begin : g_fan
        ftos_fan_model fan (.ref_clk_i(ref_clk_i), .duty_i(duty_o[f]),
            .stall_i(stall[f]), .count_o(cnt[f]));
        assign tach_i[f] = {cnt[f], 16'h8000};
    end

    initial
    begin
        ref_clk_i = 0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        repeat (4000) @(posedge ref_clk_i);
        n_mismatch++;
        end_of_test();
    end
    task automatic tally(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_rd(input ftos_byte_type e);
        tally(reg_rdata_o === e, "read data");
    endtask
    task automatic cmp_duty(input logic [23:0] e);
        tally(duty_o === e, "duty");
    endtask
    task automatic cmp_ovr(input logic [3:0] e);
        tally(override_o === e, "override");
    endtask
    task automatic cmp_spin(input logic [6:0] e);
        tally({speed_off_o, spinning_o} === e, "spin state");
    endtask
    always
    begin
        @(obs_ev);
        while (notes.size() > 0)
        begin
            nt = notes.pop_front();
            case (nt.kind)
                0: cmp_rd(nt.val[7:0]);
                1: cmp_duty(nt.val);
                2: cmp_ovr(nt.val[3:0]);
                default: cmp_spin(nt.val[6:0]);
            endcase
        end
    end
    task automatic note(input int k, input logic [23:0] v);
        notes.push_back('{k, v});
        -> obs_ev;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic wr(input int i, input ftos_byte_type d);
        @(negedge ref_clk_i);
        reg_addr_i = offs[i];
        reg_wdata_i = d;
        reg_wr_i = 1;
        if (!cfg_lock_i && i < 7)
            regv[i] = (i == 6) ? (d & 8'hf7) : d;
        @(negedge ref_clk_i);
        reg_wr_i = 0;
    endtask
    task automatic rd(input int i);
        @(negedge ref_clk_i);
        reg_addr_i = offs[i];
        cyc(1);
        note(0, regv[i]);
    endtask
    task automatic heat(input int z, input int t, input logic [3:0] o,
        input logic [23:0] d);
        @(negedge ref_clk_i);
        zone_temp_i[z] = t[8:0];
        cyc(3);
        note(2, o);
        note(1, d);
    endtask
    task automatic pulse();
        @(negedge ref_clk_i);
        tick_i = 1;
        @(negedge ref_clk_i);
        tick_i = 0;
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        rst_b_i = 0;
        ce_i = 1;
        reg_addr_i = 8'h00;
        reg_wr_i = 0;
        reg_wdata_i = 8'h00;
        cfg_lock_i = 0;
        auto_mode_i = 0;
        tick_i = 0;
        stall = 3'b000;
        zone_temp_i = '0;
        start_lim_i = {4{8'h32}};
        for (int f = 0; f < 3; f++)
        begin
            fan_cfg_i[f] = {8'h00, 8'h40, 8'hc0, 4'h0, 16'h0002};
            fan_cfg_i[f].ramp = 8'($random(seed));
        end
        cyc(2);
        rst_b_i = 1;
        cyc(2);
        note(1, {fan_cfg_i[2].ramp, fan_cfg_i[1].ramp, fan_cfg_i[0].ramp});
        for (int i = 0; i < 8; i++)
            rd(i);
        for (int i = 0; i < 7; i++)
        begin
            wr(i, 8'($random(seed)));
            rd(i);
        end
        for (int i = 0; i < 4; i++)
            wr(i, 8'h80);
        wr(4, 8'hf4);
        auto_mode_i = 1;
        for (int z = 0; z < 4; z++)
        begin
            wr((z + 1) % 4, 8'h64);
            heat(z, 101, 4'b0001 << z, 24'hffffff);
            wr((z + 1) % 4, 8'h80);
            heat(z, 101, 4'h0, 24'h0);
        end
        wr(1, 8'h64);
        heat(0, 101, 4'h1, 24'hffffff);
        heat(0, 86, 4'h1, 24'hffffff);
        heat(0, 85, 4'h0, 24'h0);
        wr(1, 8'h7f);
        heat(0, 255, 4'h0, 24'h0);
        wr(1, 8'h88);
        heat(0, -119, 4'h1, 24'hffffff);
        heat(0, -127, 4'h1, 24'hffffff);
        heat(0, -128, 4'h0, 24'h0);
        wr(1, 8'h7f);
        // Early exit and speed-off bits were randomised above; clear them
        wr(6, 8'h00);
        fan_cfg_i[0].zone_map = 4'h1;
        heat(0, 50, 4'h0, 24'hff);
        cyc(10);
        note(3, 7'h01);
        pulse();
        cyc(1);
        note(3, 7'h01);
        pulse();
        cyc(2);
        note(3, 7'h00);
        heat(0, 50, 4'h0, 24'h40);
        rp = fan_cfg_i[0].ramp;
        rp = (rp < 8'h40) ? 8'h40 : ((rp > 8'hc0) ? 8'hc0 : rp);
        heat(0, 51, 4'h0, {16'h0, rp});
        heat(0, 40, 4'h0, 24'h40);
        heat(0, 35, 4'h0, 24'h40);
        heat(0, 34, 4'h0, 24'h0);
        wr(6, 8'h01);
        stall[0] = 1;
        heat(0, 50, 4'h0, 24'hff);
        cyc(10);
        note(3, 7'h01);
        stall[0] = 0;
        cyc(12);
        note(3, 7'h00);
        wr(6, 8'hf9);
        cyc(2);
        note(3, 7'h78);
        cfg_lock_i = 1;
        for (int i = 0; i < 8; i++)
        begin
            wr(i, ~regv[i]);
            rd(i);
        end
        cyc(1);
        end_of_test();
    end
endmodule
